// ===== rtl/irc_pkg.sv
// Purpose: constants and types for the receive context start and accept logic
// Assumes: one clock, plain register port, eight contexts
// Notes: register index of a context adds CTX_STRIDE times the context number
// How it works
// - setting run launches a fetch at the context's program pointer address
// - eight contexts, registers repeat every 32 bytes from the base offsets
// - pointer bits 31:4 hold the 16-byte aligned program start address
// - match bits 31..28 accept tags 11b, 10b, 01b, 00b
// - match bits 27 and 7 always read zero
// - start-on-cycle withholds reception until start value equals cycle value
// - cycle value is seconds bits 26:25 above count bits 24:12
// - wait-select 11b compares match bits 11:8 against packet sync
// - filter bit with tag one enable needs sync top bits 00b
// - sync restriction touches only tag 01b packets
// - filter lock forces the marker filter bit to one, writes ignored
// - bits 5:0 select the single accepted channel
// - multi-channel mode uses the shared channel mask instead
// - start-on-cycle enable clears once a cycle-started context is active
package irc_pkg;
    localparam int          NUM_CTX        = 8;
    localparam logic [11:0] PTR_BASE       = 12'h40C;
    localparam logic [15:0] MATCH_BASE     = 16'h410C;
    localparam logic [15:0] CTRL_BASE      = 16'h4100; // context control, own offset
    localparam logic [15:0] MASK_HI_OFS    = 16'h4200; // channel mask 63:32
    localparam logic [15:0] MASK_LO_OFS    = 16'h4204; // channel mask 31:0
    localparam logic [15:0] LINK_CTRL_OFS  = 16'h4208; // bit 0 filter lock
    localparam logic [15:0] CTX_STRIDE     = 16'h0020;
    localparam logic [31:0] MATCH_RD_MASK  = 32'hF7FF_FF7F;
    localparam int          PTR_ADDR_LSB   = 4;
    localparam int          TAG_THREE_BIT  = 31;
    localparam int          TAG_TWO_BIT    = 30;
    localparam int          TAG_ONE_BIT    = 29;
    localparam int          TAG_ZERO_BIT   = 28;
    localparam int          CYC_MSB        = 26;
    localparam int          CYC_LSB        = 12;
    localparam int          SYNC_MSB       = 11;
    localparam int          SYNC_LSB       = 8;
    localparam int          FILT_BIT       = 6;
    localparam int          CTRL_RUN_BIT   = 15;
    localparam int          CTRL_ACT_BIT   = 10;
    localparam int          CTRL_SOC_BIT   = 29;
    localparam int          CTRL_MCM_BIT   = 28;
    localparam int          CTRL_WAIT_LSB  = 0;   // wait-select 1:0, own bits
    localparam logic [1:0]  WAIT_SYNC      = 2'h3;
    localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
    typedef enum logic [1:0] {IRC_IDLE, IRC_FETCH, IRC_WAITCYC, IRC_ACTIVE} irc_state_t;
endpackage

// ===== rtl/irc_pkt_if.sv
// Purpose: carries one received packet header between top and filter
// Assumes: same clock as top
// Notes: valid is a one-cycle pulse
interface irc_pkt_if;
    logic       valid;
    logic [1:0] tag;
    logic [5:0] chan;
    logic [3:0] sync;
    modport src (output valid, output tag, output chan, output sync);
    modport dst (input  valid, input  tag, input  chan, input  sync);
endinterface

// ===== rtl/irc_filter.sv
// Purpose: per-context accept decision for one packet header
// Assumes: header stable in the valid cycle
// Notes: purely combinational, top registers the result
module irc_filter (
    irc_pkt_if.dst     pkt,
    input  wire logic [31:0] match_word,
    input  wire logic        multi_mode,
    input  wire logic [63:0] chan_mask,
    input  wire logic        wait_sync,
    output logic             accept
);
    logic tag_ok;
    logic chan_ok;
    logic filt_ok;
    logic sync_ok;
    // tag enable picked by the tag value itself
    assign tag_ok  = match_word[irc_pkg::TAG_ZERO_BIT + {3'h0, pkt.tag}];
    // mask replaces the channel field in multi-channel mode
    assign chan_ok = multi_mode ? chan_mask[pkt.chan]
                   : (pkt.chan == match_word[5:0]);
    // restriction only bites tag 01b packets
    assign filt_ok = !(match_word[irc_pkg::FILT_BIT] && match_word[irc_pkg::TAG_ONE_BIT]
                       && pkt.tag == 2'h1) || (pkt.sync[3:2] == 2'h0);
    assign sync_ok = !wait_sync
                   || pkt.sync == match_word[irc_pkg::SYNC_MSB:irc_pkg::SYNC_LSB];
    assign accept  = pkt.valid && tag_ok && chan_ok && filt_ok && sync_ok;
endmodule

// ===== rtl/irc_top.sv
// Purpose: start and accept logic for eight isochronous receive contexts
// Assumes: register port, link delivers headers and cycle timer on core_clk
// Notes: descriptor engine sits outside; fetch_req hands it an address
module irc_top (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    input  wire logic [31:0] cycle_timer,
    input  wire logic        pkt_valid,
    input  wire logic [1:0]  pkt_tag,
    input  wire logic [5:0]  pkt_chan,
    input  wire logic [3:0]  pkt_sync,
    input  wire logic        fetch_done,
    output logic             fetch_req,
    output logic [2:0]       fetch_ctx,
    output logic [31:0]      fetch_addr,
    output logic [3:0]       fetch_count,
    output logic [7:0]       pkt_accept
);
    localparam int N = irc_pkg::NUM_CTX;
    localparam logic [31:0] ACT_MASK = 32'h0000_0001 << irc_pkg::CTRL_ACT_BIT;
    // one clock domain: the checks at the bottom may leave clock and reset out
    default clocking dcb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic [31:0]      ptr_r   [N];
    logic [31:0]      match_r [N];
    logic [31:0]      ctrl_r  [N];
    irc_pkg::irc_state_t st_r [N];
    logic [31:0]      mask_hi_r;
    logic [31:0]      mask_lo_r;
    logic             lock_r;
    logic [31:0]      reg_rdata_r;
    logic [7:0]       accept_r;
    logic [7:0]       acc_w;
    logic [7:0]       req_w;
    logic [7:0]       run_rise;
    logic [7:0]       run_d_r;
    logic             busy_r;
    logic [2:0]       busy_ctx_r;
    logic [14:0]      cyc_now;
    logic [2:0]       grant;
    logic             grant_ok;
    irc_pkt_if        pkt ();

    // index of a context from a byte address, bit 3 as valid flag, zero on a miss
    function automatic logic [3:0] ctx_of(input logic [15:0] a, input logic [15:0] base);
        logic [15:0] d;
        d = a - base;
        if (a >= base && d[4:0] == 5'h00 && d[15:5] < 11'(N))
            return {1'b1, d[7:5]};
        return 4'h0;
    endfunction

    assign pkt.valid = pkt_valid;
    assign pkt.tag   = pkt_tag;
    assign pkt.chan  = pkt_chan;
    assign pkt.sync  = pkt_sync;
    // seconds low bits joined above the count field
    assign cyc_now = {cycle_timer[26:25], cycle_timer[24:12]};

    // address decode
    logic [3:0] ptr_hit;
    logic [3:0] match_hit;
    logic [3:0] ctrl_hit;
    assign ptr_hit   = ctx_of(reg_addr, {4'h0, irc_pkg::PTR_BASE});
    assign match_hit = ctx_of(reg_addr, irc_pkg::MATCH_BASE);
    assign ctrl_hit  = ctx_of(reg_addr, irc_pkg::CTRL_BASE);

    // lowest pending launch request wins the fetch port
    always_comb
    begin
        grant    = 3'h0;
        grant_ok = 1'b0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req_w[i])
            begin
                grant    = 3'(i);
                grant_ok = 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : ctx
            logic wsel;
            assign wsel = ctrl_r[g][irc_pkg::CTRL_WAIT_LSB +: 2] == irc_pkg::WAIT_SYNC;
            assign run_rise[g] = ctrl_r[g][irc_pkg::CTRL_RUN_BIT] && !run_d_r[g];
            assign req_w[g]    = st_r[g] == irc_pkg::IRC_FETCH && !busy_r;
            irc_filter u_filt (
                .pkt        (pkt),
                .match_word (match_r[g]),
                .multi_mode (ctrl_r[g][irc_pkg::CTRL_MCM_BIT]),
                .chan_mask  ({mask_hi_r, mask_lo_r}),
                .wait_sync  (wsel),
                .accept     (acc_w[g])
            );
        end
    endgenerate

    // per-context start sequencing
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < N; i++)
            begin
                st_r[i]    <= irc_pkg::IRC_IDLE;
                ptr_r[i]   <= irc_pkg::RESET_WORD;
                match_r[i] <= irc_pkg::RESET_WORD;
                ctrl_r[i]  <= irc_pkg::RESET_WORD;
            end
            run_d_r    <= 8'h00;
            busy_r     <= 1'b0;
            busy_ctx_r <= 3'h0;
            accept_r   <= 8'h00;
        end
        else
        begin
            run_d_r <= {ctrl_r[7][15], ctrl_r[6][15], ctrl_r[5][15], ctrl_r[4][15],
                        ctrl_r[3][15], ctrl_r[2][15], ctrl_r[1][15], ctrl_r[0][15]};
            for (int i = 0; i < N; i++)
            begin
                if (reg_wr && ptr_hit == {1'b1, 3'(i)})
                    ptr_r[i] <= reg_wdata;
                if (reg_wr && match_hit == {1'b1, 3'(i)})
                    match_r[i] <= reg_wdata & irc_pkg::MATCH_RD_MASK;
                if (lock_r)
                    match_r[i][irc_pkg::FILT_BIT] <= 1'b1;
                if (reg_wr && ctrl_hit == {1'b1, 3'(i)})
                    ctrl_r[i] <= (reg_wdata & ~ACT_MASK) | (ctrl_r[i] & ACT_MASK); // active is hardware-owned
                case (st_r[i])
                    irc_pkg::IRC_IDLE:
                        if (run_rise[i])
                            st_r[i] <= irc_pkg::IRC_FETCH;
                    irc_pkg::IRC_FETCH:
                        if (req_w[i] && grant == 3'(i))
                            st_r[i] <= irc_pkg::IRC_WAITCYC;
                    irc_pkg::IRC_WAITCYC:
                        if (!busy_r || busy_ctx_r != 3'(i) || fetch_done)
                        begin
                            if (!ctrl_r[i][irc_pkg::CTRL_SOC_BIT]
                                || match_r[i][irc_pkg::CYC_MSB:irc_pkg::CYC_LSB] == cyc_now)
                            begin
                                st_r[i] <= irc_pkg::IRC_ACTIVE;
                                ctrl_r[i][irc_pkg::CTRL_SOC_BIT] <= 1'b0;
                                ctrl_r[i][irc_pkg::CTRL_ACT_BIT] <= 1'b1;
                            end
                        end
                    irc_pkg::IRC_ACTIVE:
                        ;
                    default:
                        st_r[i] <= irc_pkg::IRC_IDLE;
                endcase
                if (!ctrl_r[i][irc_pkg::CTRL_RUN_BIT])
                begin
                    st_r[i] <= irc_pkg::IRC_IDLE;
                    ctrl_r[i][irc_pkg::CTRL_ACT_BIT] <= 1'b0;
                end
                // only an active context may take packets
                accept_r[i] <= acc_w[i] && st_r[i] == irc_pkg::IRC_ACTIVE;
            end
            if (grant_ok)
            begin
                busy_r     <= 1'b1;
                busy_ctx_r <= grant;
            end
            else if (fetch_done)
                busy_r <= 1'b0;
        end
    end

    // shared registers
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mask_hi_r <= irc_pkg::RESET_WORD;
            mask_lo_r <= irc_pkg::RESET_WORD;
            lock_r    <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == irc_pkg::MASK_HI_OFS)
                mask_hi_r <= reg_wdata;
            else if (reg_addr == irc_pkg::MASK_LO_OFS)
                mask_lo_r <= reg_wdata;
            else if (reg_addr == irc_pkg::LINK_CTRL_OFS)
                lock_r <= reg_wdata[0];
        end
    end

    // read mux; unmapped addresses read zero
    logic [31:0] rd_w;
    assign rd_w = ptr_hit[3]   ? ptr_r[ptr_hit[2:0]]
                : match_hit[3] ? (match_r[match_hit[2:0]] & irc_pkg::MATCH_RD_MASK)
                : ctrl_hit[3]  ? ctrl_r[ctrl_hit[2:0]]
                : reg_addr == irc_pkg::MASK_HI_OFS   ? mask_hi_r
                : reg_addr == irc_pkg::MASK_LO_OFS   ? mask_lo_r
                : reg_addr == irc_pkg::LINK_CTRL_OFS ? {31'h0, lock_r}
                : 32'h0000_0000;

    // fetch registers: aligned address and count taken from the pointer
    logic [31:0] faddr_r;
    logic [3:0]  fcnt_r;
    logic [2:0]  fctx_r;
    logic        freq_r;
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata_r <= 32'h0000_0000;
            faddr_r     <= 32'h0000_0000;
            fcnt_r      <= 4'h0;
            fctx_r      <= 3'h0;
            freq_r      <= 1'b0;
        end
        else
        begin
            reg_rdata_r <= reg_rd ? rd_w : 32'h0000_0000;
            freq_r      <= grant_ok;
            if (grant_ok)
            begin
                faddr_r <= {ptr_r[grant][31:irc_pkg::PTR_ADDR_LSB], 4'h0};
                fcnt_r  <= ptr_r[grant][3:0];
                fctx_r  <= grant;
            end
        end
    end

    assign reg_rdata   = reg_rdata_r;
    assign fetch_req   = freq_r;
    assign fetch_addr  = faddr_r;
    assign fetch_count = fcnt_r;
    assign fetch_ctx   = fctx_r;
    assign pkt_accept  = accept_r;

    // assertions; most watch contexts 2 and 4, the ones the scenarios run; lock_force_a and match_store_a watch contexts 0 and 7,
    // rsvd_zero_a and lock_read_a watch a read of any match register, since every context is the same copy of the logic
    logic [63:0] mask_w;
    assign mask_w = {mask_hi_r, mask_lo_r};
    // launch steps: a pending context wins the port, then its request goes out
    sequence launch_req_s;
        st_r[2] == irc_pkg::IRC_FETCH && !busy_r && req_w[1:0] == 2'h0;
    endsequence
    sequence launch_out_s;
        fetch_req && fetch_ctx == 3'h2;
    endsequence
    // cycle-matched start steps: waiting, then active one cycle later
    sequence cyc_wait_s;
        st_r[4] == irc_pkg::IRC_WAITCYC;
    endsequence
    sequence cyc_start_s;
        cyc_wait_s ##1 st_r[4] == irc_pkg::IRC_ACTIVE;
    endsequence
    logic [3:0] h0;
    assign h0 = ctx_of(reg_addr, irc_pkg::MATCH_BASE);
    rsvd_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (reg_rd && h0[3]) |=> (reg_rdata[27] == 1'b0 && reg_rdata[7] == 1'b0))
        else $error("reserved match bits read nonzero");
    fetch_align_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        fetch_req |-> fetch_addr[3:0] == 4'h0)
        else $error("fetch address not aligned");
    lock_force_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        lock_r ##1 lock_r |-> match_r[0][irc_pkg::FILT_BIT])
        else $error("filter bit not forced by lock");
    soc_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        cyc_start_s |-> !ctrl_r[4][irc_pkg::CTRL_SOC_BIT])
        else $error("start-on-cycle not cleared");
    hold_cycle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (st_r[4] == irc_pkg::IRC_WAITCYC && ctrl_r[4][irc_pkg::CTRL_SOC_BIT]
         && match_r[4][irc_pkg::CYC_MSB:irc_pkg::CYC_LSB] != cyc_now) |=> st_r[4] != irc_pkg::IRC_ACTIVE)
        else $error("context started off cycle");
    launch_fetch_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (run_rise[2] && !busy_r && run_rise[1:0] == 2'h0 && req_w == 8'h00)
        |=> ##[1:2] fetch_req)
        else $error("run did not launch a fetch");
    no_accept_idle_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        st_r[2] != irc_pkg::IRC_ACTIVE |=> !pkt_accept[2])
        else $error("inactive context accepted");
    tag_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pkt_valid && !match_r[2][irc_pkg::TAG_ZERO_BIT + 32'(pkt_tag)]) |=> !pkt_accept[2])
        else $error("disabled tag accepted");
    filt_accept_tag_value_one_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pkt_valid && pkt_tag == 2'h1 && match_r[2][irc_pkg::FILT_BIT] && pkt_sync[3:2] != 2'h0)
        |=> !pkt_accept[2])
        else $error("tag one passed sync filter");
    chan_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pkt_valid && !ctrl_r[2][irc_pkg::CTRL_MCM_BIT] && pkt_chan != match_r[2][5:0])
        |=> !pkt_accept[2])
        else $error("wrong channel accepted");

    // launch path
    run_to_fetch_a: assert property ((run_rise[2] && st_r[2] == irc_pkg::IRC_IDLE)
        |=> st_r[2] == irc_pkg::IRC_FETCH)
        else $error("run edge did not start a launch");
    grant_ctx_a: assert property (launch_req_s
        |=> launch_out_s)
        else $error("granted launch gave no fetch");
    one_fetch_a: assert property (fetch_req
        |=> !fetch_req)
        else $error("fetch request longer than a cycle");
    fetch_first_a: assert property ((st_r[2] == irc_pkg::IRC_WAITCYC
        && busy_r && busy_ctx_r == 3'h2 && !fetch_done)
        |=> st_r[2] != irc_pkg::IRC_ACTIVE)
        else $error("context active before its fetch ended");
    act_flag_a: assert property (
        ctrl_r[2][irc_pkg::CTRL_ACT_BIT] == (st_r[2] == irc_pkg::IRC_ACTIVE))
        else $error("active flag disagrees with state");

    // register side
    rd_quiet_a: assert property (!reg_rd
        |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    ptr_store_a: assert property ((reg_wr && ptr_hit == 4'hA)
        |=> ptr_r[2] == $past(reg_wdata))
        else $error("pointer write not stored");
    match_store_a: assert property ((reg_wr && match_hit == 4'hF)
        |=> (match_r[7][27] == 1'b0 && match_r[7][7] == 1'b0))
        else $error("reserved match bits stored");
    lock_read_a: assert property (lock_r ##1 (lock_r && reg_rd && match_hit[3])
        |=> reg_rdata[irc_pkg::FILT_BIT])
        else $error("locked filter bit read as zero");

    // start and accept path
    cyc_go_a: assert property ((st_r[4] == irc_pkg::IRC_WAITCYC && !busy_r
        && ctrl_r[4][irc_pkg::CTRL_RUN_BIT] && match_r[4][irc_pkg::CYC_MSB:irc_pkg::CYC_LSB] == cyc_now)
        |=> st_r[4] == irc_pkg::IRC_ACTIVE)
        else $error("context missed its start cycle");
    sync_gate_a: assert property ((pkt_valid && ctrl_r[4][1:0] == irc_pkg::WAIT_SYNC
        && pkt_sync != match_r[4][irc_pkg::SYNC_MSB:irc_pkg::SYNC_LSB])
        |=> !pkt_accept[4])
        else $error("packet with wrong sync accepted");
    mask_gate_a: assert property ((pkt_valid && ctrl_r[2][irc_pkg::CTRL_MCM_BIT] && !mask_w[pkt_chan])
        |=> !pkt_accept[2])
        else $error("masked channel accepted");
    tag_free_a: assert property ((pkt_valid && st_r[2] == irc_pkg::IRC_ACTIVE && pkt_tag == 2'h3
        && match_r[2][irc_pkg::TAG_THREE_BIT] && !ctrl_r[2][irc_pkg::CTRL_MCM_BIT]
        && pkt_chan == match_r[2][5:0] && ctrl_r[2][1:0] != irc_pkg::WAIT_SYNC)
        |=> pkt_accept[2])
        else $error("open tag packet refused");
endmodule

// ===== tb/irc_link_model.sv
// Purpose: far side of the context block, the link cycle timer and the descriptor engine
// Assumes: one clock shared with the block
// Notes: fetch_done answers each fetch_req after LAT cycles; a load sets any timer value
module irc_link_model #(
    parameter int LAT = 3
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        fetch_req,
    input  wire logic        ld,
    input  wire logic [31:0] ld_val,
    output logic             fetch_done,
    output logic [31:0]      cycle_timer
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt;

    // count field steps once a clock so tests stay short; a carry spills into seconds
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cycle_timer <= 32'h0000_0000;
        else if (ld)
            cycle_timer <= ld_val;
        else
            cycle_timer <= cycle_timer + 32'h0000_1000;
    end

    // a slow engine: one fetch in flight, its done pulse lasts one cycle
    always @(posedge core_clk or posedge sys_rst)
    begin
        fetch_done <= 1'b0;
        if (sys_rst)
            wait_cnt <= 0;
        else if (fetch_req === 1'b1)
            wait_cnt <= LAT;
        else if (wait_cnt == 1)
        begin
            wait_cnt <= 0;
            fetch_done <= 1'b1;
        end
        else if (wait_cnt > 1)
            wait_cnt <= wait_cnt - 1;
    end
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench for the receive context start and accept logic
// Assumes: link model answers fetches and runs the cycle timer
// Notes: every scenario is a task; tasks are entered just after a rising edge
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] cycle_timer;
    logic        pkt_valid = 1'b0;
    logic [1:0]  pkt_tag = 2'h0;
    logic [5:0]  pkt_chan = 6'h00;
    logic [3:0]  pkt_sync = 4'h0;
    logic        fetch_done;
    logic        fetch_req;
    logic [2:0]  fetch_ctx;
    logic [31:0] fetch_addr;
    logic [3:0]  fetch_count;
    logic [7:0]  pkt_accept;
    logic        ld = 1'b0;
    logic [31:0] ld_val = 32'h0000_0000;
    int          bad_count = 0;
    int          check_count = 0;

    irc_top i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cycle_timer(cycle_timer),
        .pkt_valid(pkt_valid), .pkt_tag(pkt_tag), .pkt_chan(pkt_chan), .pkt_sync(pkt_sync),
        .fetch_done(fetch_done), .fetch_req(fetch_req), .fetch_ctx(fetch_ctx), .fetch_addr(fetch_addr),
        .fetch_count(fetch_count), .pkt_accept(pkt_accept));
    irc_link_model i_link (.core_clk(core_clk), .sys_rst(sys_rst), .fetch_req(fetch_req), .ld(ld),
        .ld_val(ld_val), .fetch_done(fetch_done), .cycle_timer(cycle_timer));

    // 200 MHz clock
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end

    function automatic logic [15:0] ra(input logic [15:0] b, input int n);
        return b + irc_pkg::CTX_STRIDE * 16'(n);
    endfunction

    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // an idle edge keeps back-to-back calls from driving the strobe twice at once
        @(posedge core_clk);
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [31:0] v);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
        @(posedge core_clk);
    endtask

    task automatic tload(input logic [31:0] v);
        ld <= 1'b1;
        ld_val <= v;
        @(posedge core_clk);
        ld <= 1'b0;
    endtask

    // one header pulse, accept bit of context c looked at in the cycle after
    task automatic pk(input logic [1:0] t, input logic [5:0] ch, input logic [3:0] s, input int c,
        input logic e);
        pkt_valid <= 1'b1;
        pkt_tag <= t;
        pkt_chan <= ch;
        pkt_sync <= s;
        @(posedge core_clk);
        pkt_valid <= 1'b0;
        #1;
        chk1("pkt_accept", e, pkt_accept[c]);
        @(posedge core_clk);
    endtask

    task automatic wait_fetch(input logic [2:0] c, input logic [31:0] ad, input logic [3:0] cnt);
        int i;
        i = 0;
        #1;
        while (i < 20 && fetch_req !== 1'b1)
        begin
            @(posedge core_clk);
            #1;
            i++;
        end
        chk1("fetch_req", 1'b1, fetch_req);
        chk32("fetch_ctx", {29'h0, c}, {29'h0, fetch_ctx});
        chk32("fetch_addr", ad, fetch_addr);
        chk32("fetch_count", {28'h0, cnt}, {28'h0, fetch_count});
        @(posedge core_clk);
    endtask

    task automatic wait_act(input int n);
        logic [31:0] v;
        v = 32'h0000_0000;
        for (int i = 0; i < 12 && v[10] !== 1'b1; i++)
            rd(ra(irc_pkg::CTRL_BASE, n), v);
        chk1("active", 1'b1, v[10]);
    endtask

    task automatic t_regs();
        logic [31:0] v;
        rd(ra({4'h0, irc_pkg::PTR_BASE}, 5), v);
        chk32("ptr reset", 32'h0000_0000, v);
        for (int n = 0; n < 8; n++)
            wr(ra({4'h0, irc_pkg::PTR_BASE}, n), 32'hA5A5_0000 + 32'h0101_0011 * 32'(n));
        for (int n = 0; n < 8; n++)
        begin
            rd(ra({4'h0, irc_pkg::PTR_BASE}, n), v);
            chk32("ptr ctx", 32'hA5A5_0000 + 32'h0101_0011 * 32'(n), v);
        end
        wr(ra(irc_pkg::MATCH_BASE, 7), 32'hFFFF_FFFF);
        rd(ra(irc_pkg::MATCH_BASE, 7), v);
        chk32("match reserved", 32'hF7FF_FF7F, v);
        wr(16'h0000, 32'h1234_5678);
        rd(16'h0000, v);
        chk32("unmapped", 32'h0000_0000, v);
        $display("test regs done");
    endtask

    task automatic t_lock();
        logic [31:0] v;
        wr(irc_pkg::LINK_CTRL_OFS, 32'h0000_0001);
        wr(ra(irc_pkg::MATCH_BASE, 0), 32'h1000_0005);
        rd(ra(irc_pkg::MATCH_BASE, 0), v);
        chk32("match locked", 32'h1000_0045, v);
        wr(irc_pkg::LINK_CTRL_OFS, 32'h0000_0000);
        wr(ra(irc_pkg::MATCH_BASE, 0), 32'h1000_0005);
        rd(ra(irc_pkg::MATCH_BASE, 0), v);
        chk32("match unlocked", 32'h1000_0005, v);
        $display("test lock done");
    endtask

    task automatic t_accept();
        wr(ra({4'h0, irc_pkg::PTR_BASE}, 2), 32'h1234_5678);
        wr(ra(irc_pkg::MATCH_BASE, 2), 32'hA000_0045);
        wr(ra(irc_pkg::CTRL_BASE, 2), 32'h0000_8000);
        wait_fetch(3'h2, 32'h1234_5670, 4'h8);
        wait_act(2);
        pk(2'h3, 6'h05, 4'hC, 2, 1'b1);
        pk(2'h2, 6'h05, 4'h0, 2, 1'b0);
        pk(2'h1, 6'h05, 4'h3, 2, 1'b1);
        pk(2'h1, 6'h05, 4'h4, 2, 1'b0);
        pk(2'h0, 6'h05, 4'h0, 2, 1'b0);
        pk(2'h3, 6'h06, 4'h0, 2, 1'b0);
        wr(ra(irc_pkg::MATCH_BASE, 2), 32'hA000_0005);
        pk(2'h1, 6'h05, 4'h4, 2, 1'b1);
        $display("test accept done");
    endtask

    task automatic t_multi();
        wr(ra(irc_pkg::CTRL_BASE, 2), 32'h0000_0000);
        wr(irc_pkg::MASK_LO_OFS, 32'h0000_0200);
        wr(irc_pkg::MASK_HI_OFS, 32'h8000_0000);
        wr(ra(irc_pkg::CTRL_BASE, 2), 32'h1000_8000);
        wait_fetch(3'h2, 32'h1234_5670, 4'h8);
        wait_act(2);
        pk(2'h3, 6'h09, 4'h0, 2, 1'b1);
        pk(2'h3, 6'h3F, 4'h0, 2, 1'b1);
        pk(2'h3, 6'h05, 4'h0, 2, 1'b0);
        $display("test multi done");
    endtask

    task automatic t_cycle();
        logic [31:0] v;
        wr(ra({4'h0, irc_pkg::PTR_BASE}, 4), 32'h0000_1001);
        wr(ra(irc_pkg::MATCH_BASE, 4), 32'hF600_5907);
        tload(32'h0200_5000);
        wr(ra(irc_pkg::CTRL_BASE, 4), 32'h2000_8003);
        wait_fetch(3'h4, 32'h0000_1000, 4'h1);
        repeat (8) @(posedge core_clk);
        tload(32'h0200_5000);
        rd(ra(irc_pkg::CTRL_BASE, 4), v);
        chk1("held active", 1'b0, v[10]);
        chk1("held soc", 1'b1, v[29]);
        pk(2'h3, 6'h07, 4'h9, 4, 1'b0);
        tload(32'h0E00_5000);
        wait_act(4);
        rd(ra(irc_pkg::CTRL_BASE, 4), v);
        chk1("soc cleared", 1'b0, v[29]);
        pk(2'h3, 6'h07, 4'h9, 4, 1'b1);
        pk(2'h3, 6'h07, 4'h8, 4, 1'b0);
        $display("test cycle done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence: reset for 10 cycles, then the scenarios
    initial
    begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_lock();
        t_accept();
        t_multi();
        t_cycle();
        finish_test();
    end

    // the scenarios need a few hundred cycles; this limit leaves wide margin
    initial
    begin
        #100us;
        bad_count++;
        finish_test();
    end
endmodule
